// *** core/ccs_pkg.sv ***
// constants and carriers for the core status, sfr map and clocking block
// assumes one 200 MHz system clock; the cpu datapath drives the request structs
package ccs_pkg;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // sfr addresses
    // ****************************************
    localparam logic [7:0] SFR_STATUS_ADDR  = 8'h00_D0;
    localparam logic [7:0] SFR_SYSCTL_ADDR  = 8'h00_B1;
    localparam logic [7:0] SFR_PWR2_ADDR    = 8'h00_88;
    localparam logic [7:0] SFR_USBCTL_ADDR  = 8'h00_C1;
    localparam logic [7:0] SFR_AREA_BASE    = 8'h00_80;
    localparam logic [2:0] SFR_BIT_ADDR_LOW = 3'h0;

    // ****************************************
    // status word fields
    // ****************************************
    localparam int STW_CARRY  = 7;
    localparam int STW_AUX    = 6;
    localparam int STW_UFA    = 5;
    localparam int STW_BANK_H = 4;
    localparam int STW_BANK_L = 3;
    localparam int STW_OVF    = 2;
    localparam int STW_UFB    = 1;
    localparam int STW_PARITY = 0;
    localparam logic [7:0] STW_RESET = 8'h00_00;

    // ****************************************
    // system control and power control 2 fields
    // ****************************************
    localparam int SYSCTL_MAP = 4;
    localparam logic [7:0] SYSCTL_RESET = 8'h00_20;
    localparam logic [7:0] SYSCTL_FIXED = 8'h00_20;
    localparam logic [7:0] PWR2_MASK    = 8'h00_90;
    localparam logic [7:0] PWR2_RESET   = 8'h00_00;

    // ****************************************
    // usb device control fields
    // ****************************************
    localparam int USBCTL_CLK_EN = 7;
    localparam int USBCTL_SPEED  = 6;
    localparam int USBCTL_PLL_EN = 5;
    localparam logic [7:0] USBCTL_MASK  = 8'h00_E0;
    localparam logic [7:0] USBCTL_RESET = 8'h00_00;

    // ****************************************
    // memory sizes and clocking figures
    // ****************************************
    localparam int IRAM_BYTES    = 256;
    localparam int SFR_BYTES     = 128;
    localparam int XDATA_AW      = 16;
    localparam int BANK_BYTES    = 8;
    localparam int CLK_MHZ       = 200;
    localparam int FS_USB_MHZ    = 48;
    localparam int LS_USB_MHZ    = 6;
    localparam int LS_DIVIDE     = 2;
    localparam logic [2:0] FS_PLL_FACTOR = 3'h4;
    localparam int RST_HOLD_OSC  = 12;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       bit_op;
        logic [2:0] bit_idx;
    } ccs_sfr_req_t;

    typedef struct packed {
        logic cy_we;
        logic cy;
        logic ac_we;
        logic ac;
        logic ov_we;
        logic ov;
    } ccs_alu_flags_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
    } ccs_iram_req_t;

endpackage

// *** core/ccs_core.sv ***
// core status word, sfr map select, bit decode, reset sync and usb clock control
// assumes the cpu datapath presents sfr, flag, accumulator and iram requests on core_clk
//
// Summary of operation
// - status word keeps carry, overflow, aux carry from alu and two software flags
// - two bank bits pick one of four eight-byte banks at 00, 08, 10, 18
// - parity bit follows odd count of ones in accumulator after each instruction
// - status word sits at sfr D0 and resets to zero
// - full speed usb clock is 48 MHz for 12 Mbit/s
// - low speed usb clock is 6 MHz for 1.5 Mbit/s; halving the 200 MHz system clock gives 100 MHz here
// - low speed clock is system clock divided by two
// - full speed clock comes from a times-four multiplier
// - pll enable bit in usb device control turns the multiplier on or off
// - speed bit picks multiplied clock when set, divided clock when clear
// - usb clock enable bit gates the selected clock to the usb logic
// - sfr space has standard and mapped parts; only power control 2 is mapped
// - map bit zero reaches standard part, one reaches mapped part
// - map bit holds until software rewrites it or a reset clears it
// - sfrs at addresses with low three bits zero allow single-bit access
// - system control sits at B1 with reset pattern XX10XXXX
// - 256 bytes internal data memory and a separate 128-byte sfr area
// - up to 64 Kbyte external data memory is addressed
// - power control 2 at mapped 88, reachable only while map bit set
module ccs_core
(
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        arst_n,
    input  wire logic                        reset_pin,
    output logic                             core_reset,
    // sfr access from the cpu
    input  wire ccs_pkg::ccs_sfr_req_t       sfr_req,
    output logic [7:0]                       sfr_rdata,
    output logic                             sfr_claim,
    output logic                             sfr_bit_ok,
    // alu and accumulator
    input  wire ccs_pkg::ccs_alu_flags_t     alu_flags,
    input  wire logic [7:0]                  acc_value,
    input  wire logic                        instr_done,
    output logic [7:0]                       status_word,
    // working register redirect
    input  wire logic [2:0]                  wreg_idx,
    output logic [7:0]                       wreg_addr,
    // internal data memory
    input  wire ccs_pkg::ccs_iram_req_t      iram_req,
    output logic [7:0]                       iram_rdata,
    // external data memory
    input  wire logic [15:0]                 xdata_addr_in,
    output logic [15:0]                      xdata_addr,
    // mapped power control contents
    output logic [7:0]                       pwr2_value,
    // usb clock control
    output logic                             usb_pll_enable,
    output logic [2:0]                       usb_pll_factor,
    output logic                             usb_ls_clk,
    output logic                             usb_fs_select,
    output logic                             usb_clk_gate
);
    timeunit 1ns;
    timeprecision 100ps;
    import ccs_pkg::*;

    // ****************************************
    // reset synchroniser
    // ****************************************
    logic rst_meta;
    logic rst_sync;

    // the pin is sampled, so a pulse shorter than one core_clk period may be missed
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b1;
            rst_sync <= 1'b1;
        end
        else
        begin
            rst_meta <= reset_pin;
            rst_sync <= rst_meta;
        end
    end

    assign core_reset = rst_sync;

    // ****************************************
    // sfr decode
    // ****************************************
    logic       map_sel;
    logic       hit_status;
    logic       hit_sysctl;
    logic       hit_pwr2;
    logic       hit_usbctl;
    logic       in_sfr_area;
    logic       bit_addr;
    logic       bit_acc;
    logic [7:0] bit_mask;

    assign in_sfr_area = sfr_req.addr >= SFR_AREA_BASE;
    assign bit_addr    = in_sfr_area && (sfr_req.addr[2:0] == SFR_BIT_ADDR_LOW);
    assign bit_acc     = sfr_req.bit_op && bit_addr;
    assign sfr_bit_ok  = bit_addr;

    // mapped part holds only power control 2; all else is standard
    // system control answers in both maps, else the map bit could never be cleared
    always_comb
    begin
        hit_status = 1'b0;
        hit_pwr2   = 1'b0;
        hit_usbctl = 1'b0;
        hit_sysctl = (sfr_req.addr == SFR_SYSCTL_ADDR);
        if (map_sel)
        begin
            hit_pwr2 = (sfr_req.addr == SFR_PWR2_ADDR);
        end
        else
        begin
            hit_status = (sfr_req.addr == SFR_STATUS_ADDR);
            hit_usbctl = (sfr_req.addr == SFR_USBCTL_ADDR);
        end
    end

    // one compare per bit position instead of a shift keeps the mask exactly eight bits
    for (genvar gb = 0; gb < 8; gb++)
    begin : g_bit_mask
        assign bit_mask[gb] = (sfr_req.bit_idx == 3'(gb));
    end

    // merge a byte or single-bit write into the current value
    function automatic logic [7:0] merge_wr(input logic [7:0] cur, input logic [7:0] wd,
                                            input logic is_bit, input logic [7:0] msk);
        logic [7:0] res;
        res = wd;
        if (is_bit)
            res = (cur & ~msk) | (wd[0] ? msk : 8'h00_00);
        return res;
    endfunction

    // byte access to a bit-addressable sfr is fine; bit write elsewhere is ignored
    logic wr_ok;
    assign wr_ok = sfr_req.wr && (!sfr_req.bit_op || bit_addr);

    // ****************************************
    // write strobes
    // ****************************************
    logic we_status;
    logic we_sysctl;
    logic we_pwr2;
    logic we_usbctl;

    assign we_status = wr_ok && hit_status;
    assign we_sysctl = wr_ok && hit_sysctl;
    assign we_pwr2   = wr_ok && hit_pwr2;
    assign we_usbctl = wr_ok && hit_usbctl;

    // ****************************************
    // status word
    // ****************************************
    logic [7:0] stw;
    logic [7:0] next_stw;
    logic       acc_parity;

    // one when the accumulator holds an odd count of ones, so the pair reads even
    assign acc_parity = ^acc_value;

    always_comb
    begin
        next_stw = stw;
        if (we_status)
            next_stw = merge_wr(stw, sfr_req.wdata, bit_acc, bit_mask);
        // alu updates land after a software write so hardware wins a collision
        if (alu_flags.cy_we)
            next_stw[STW_CARRY] = alu_flags.cy;
        if (alu_flags.ac_we)
            next_stw[STW_AUX] = alu_flags.ac;
        if (alu_flags.ov_we)
            next_stw[STW_OVF] = alu_flags.ov;
        // parity is hardware owned; software cannot hold it against the accumulator
        next_stw[STW_PARITY] = instr_done ? acc_parity : stw[STW_PARITY];
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            stw <= STW_RESET;
        else if (rst_sync)
            stw <= STW_RESET;
        else
            stw <= next_stw;
    end

    assign status_word = stw;

    // bank select steers working register addresses
    assign wreg_addr = {3'h0, stw[STW_BANK_H], stw[STW_BANK_L], wreg_idx};

    // ****************************************
    // system control map bit
    // ****************************************
    function automatic logic [7:0] sysctl_rd_val(input logic m);
        logic [7:0] v;
        v = SYSCTL_FIXED;
        v[SYSCTL_MAP] = m;
        return v;
    endfunction

    logic [7:0] sysctl_wr;
    assign sysctl_wr = merge_wr(sysctl_rd_val(map_sel), sfr_req.wdata, bit_acc, bit_mask);

    // only software writes and reset change the map bit; nothing else clears it
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            map_sel <= SYSCTL_RESET[SYSCTL_MAP];
        else if (rst_sync)
            map_sel <= SYSCTL_RESET[SYSCTL_MAP];
        else if (we_sysctl)
            map_sel <= sysctl_wr[SYSCTL_MAP];
    end

    // ****************************************
    // mapped power control 2
    // ****************************************
    logic [7:0] pwr2;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            pwr2 <= PWR2_RESET;
        else if (rst_sync)
            pwr2 <= PWR2_RESET;
        else if (we_pwr2)
            pwr2 <= merge_wr(pwr2, sfr_req.wdata, bit_acc, bit_mask) & PWR2_MASK;
    end

    assign pwr2_value = pwr2;

    // ****************************************
    // usb device control and clocking
    // ****************************************
    logic [7:0] usbctl;
    logic       ls_div;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            usbctl <= USBCTL_RESET;
        else if (rst_sync)
            usbctl <= USBCTL_RESET;
        else if (we_usbctl)
            usbctl <= merge_wr(usbctl, sfr_req.wdata, bit_acc, bit_mask) & USBCTL_MASK;
    end

    // divide by two for the low speed clock; 6 MHz results from a 12 MHz system clock
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            ls_div <= 1'b0;
        else
            ls_div <= ~ls_div;
    end

    // the multiplier itself is an analog macro; this block drives its controls
    assign usb_pll_enable = usbctl[USBCTL_PLL_EN];
    assign usb_pll_factor = FS_PLL_FACTOR;
    assign usb_ls_clk     = ls_div;
    assign usb_fs_select  = usbctl[USBCTL_SPEED];
    assign usb_clk_gate   = usbctl[USBCTL_CLK_EN];

    // ****************************************
    // sfr read path
    // ****************************************
    logic [7:0] rd_byte;

    always_comb
    begin
        rd_byte = 8'h00_00;
        if (hit_status)
            rd_byte = stw;
        else if (hit_sysctl)
            rd_byte = sysctl_rd_val(map_sel);
        else if (hit_pwr2)
            rd_byte = pwr2;
        else if (hit_usbctl)
            rd_byte = usbctl;
        if (bit_acc)
            rd_byte = {7'h00, rd_byte[sfr_req.bit_idx]};
    end

    logic       hit_any;
    logic [7:0] next_sfr_rdata;
    logic       next_sfr_claim;

    assign hit_any        = hit_status || hit_sysctl || hit_pwr2 || hit_usbctl;
    assign next_sfr_rdata = sfr_req.rd ? rd_byte : 8'h00;
    assign next_sfr_claim = sfr_req.rd && hit_any;

    // data and claim kept apart so either can be retimed without touching the other
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            sfr_rdata <= 8'h00;
        else
            sfr_rdata <= next_sfr_rdata;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            sfr_claim <= 1'b0;
        else
            sfr_claim <= next_sfr_claim;
    end

    // ****************************************
    // internal data memory and external address
    // ****************************************
    logic [7:0] iram [IRAM_BYTES];

    // no reset on the array: contents after power-up are undefined, as in the part
    always_ff @(posedge core_clk)
    begin
        if (iram_req.we)
            iram[iram_req.addr] <= iram_req.wdata;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            iram_rdata <= 8'h00_00;
        else
            iram_rdata <= iram[iram_req.addr];
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            xdata_addr <= 16'h0000;
        else
            xdata_addr <= xdata_addr_in;
    end

endmodule

// *** verif/ccs_chk.sv ***
// checker for ccs_core: timing relations seen at its ports
// assumes one core_clk domain; bound to every ccs_core instance
module ccs_chk
    import ccs_pkg::*;
(
    // clock and reset
    input wire logic           core_clk,
    input wire logic           arst_n,
    input wire logic           reset_pin,
    input wire logic           core_reset,
    // sfr and cpu side
    input wire ccs_sfr_req_t   sfr_req,
    input wire logic [7:0]     sfr_rdata,
    input wire logic           sfr_claim,
    input wire logic           sfr_bit_ok,
    input wire ccs_alu_flags_t alu_flags,
    input wire logic [7:0]     acc_value,
    input wire logic           instr_done,
    input wire logic [7:0]     status_word,
    input wire logic [2:0]     wreg_idx,
    input wire logic [7:0]     wreg_addr,
    input wire logic [15:0]    xdata_addr_in,
    input wire logic [15:0]    xdata_addr,
    // usb clocking
    input wire logic [2:0]     usb_pll_factor,
    input wire logic           usb_ls_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // ****
    // sequences
    // ****
    sequence s_pin_held;
        reset_pin ##1 reset_pin;
    endsequence
    sequence s_carry_load;
        alu_flags.cy_we && !core_reset;
    endsequence
    a_reset_sync: assert property (s_pin_held |=> core_reset)
        else $error("core reset not raised by held pin");
    a_reset_clear: assert property (core_reset |=> status_word == STW_RESET)
        else $error("status word not cleared in reset");
    a_carry_load: assert property (s_carry_load
        |=> status_word[STW_CARRY] == $past(alu_flags.cy))
        else $error("carry not loaded");
    a_parity_track: assert property (instr_done && !core_reset
        |=> status_word[STW_PARITY] == ^$past(acc_value))
        else $error("parity wrong");
    a_bank_redirect: assert property (wreg_addr
        == {3'h0, status_word[STW_BANK_H:STW_BANK_L], wreg_idx})
        else $error("working register address wrong");
    a_bit_decode: assert property (sfr_bit_ok == (sfr_req.addr >= SFR_AREA_BASE
        && sfr_req.addr[2:0] == SFR_BIT_ADDR_LOW))
        else $error("bit access decode wrong");
    a_unclaimed_zero: assert property (!sfr_claim |-> sfr_rdata == 8'h00)
        else $error("unclaimed read not zero");
    a_ls_toggle: assert property (1'b1 |=> usb_ls_clk != $past(usb_ls_clk))
        else $error("low speed clock not halving");
    a_pll_factor: assert property (usb_pll_factor == FS_PLL_FACTOR)
        else $error("multiplier factor wrong");
    a_xdata_copy: assert property (1'b1 |=> xdata_addr == $past(xdata_addr_in))
        else $error("external address not copied");
endmodule

bind ccs_core ccs_chk u_chk (.core_clk, .arst_n, .reset_pin, .core_reset, .sfr_req,
    .sfr_rdata, .sfr_claim, .sfr_bit_ok, .alu_flags, .acc_value, .instr_done,
    .status_word, .wreg_idx, .wreg_addr, .xdata_addr_in, .xdata_addr,
    .usb_pll_factor, .usb_ls_clk);

// *** verif/tb_top.sv ***
// self-checking bench for ccs_core against an integer model
// assumes ccs_chk is compiled alongside and bound to the core
module tb_top
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic           core_clk = 1'b0;
    logic           arst_n = 1'b0;
    logic           reset_pin = 1'b0;
    ccs_sfr_req_t   sfr_req = '0;
    ccs_alu_flags_t alu_flags = '0;
    logic [7:0]     acc_value = 8'h00;
    logic           instr_done = 1'b0;
    logic [2:0]     wreg_idx = 3'h0;
    ccs_iram_req_t  iram_req = '0;
    logic [15:0]    xdata_addr_in = 16'h0000;
    logic           core_reset, sfr_claim, sfr_bit_ok, usb_pll_enable;
    logic           usb_ls_clk, usb_fs_select, usb_clk_gate, lv;
    logic [7:0]     sfr_rdata, status_word, wreg_addr, iram_rdata, pwr2_value, d;
    logic [15:0]    xdata_addr;
    logic [2:0]     usb_pll_factor;
    logic [7:0]     ra [5] = '{SFR_STATUS_ADDR, SFR_SYSCTL_ADDR, SFR_USBCTL_ADDR, 8'h90, 8'h88};
    int             err_total = 0;
    int             checked = 0;
    int             cyc = 0;
    int             program_status_word = 0, map = 0, pwr2 = 0, usb = 0;

    ccs_core dut (.core_clk, .arst_n, .reset_pin, .core_reset, .sfr_req, .sfr_rdata,
        .sfr_claim, .sfr_bit_ok, .alu_flags, .acc_value, .instr_done, .status_word,
        .wreg_idx, .wreg_addr, .iram_req, .iram_rdata, .xdata_addr_in, .xdata_addr,
        .pwr2_value, .usb_pll_enable, .usb_pll_factor, .usb_ls_clk, .usb_fs_select,
        .usb_clk_gate);

    always #2.5 core_clk = ~core_clk;

    // ****
    // checking and model
    // ****
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // a hang costs one mismatch; the whole run needs well under this
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            err_total++;
            wrap_up();
        end
    end

    task automatic chk(string what, int exp, logic [15:0] got);
        checked++;
        if (got !== 16'(exp))
        begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // -1 marks an address the core must not claim
    function automatic int mdl_rd(logic [7:0] a);
        if (a == SFR_SYSCTL_ADDR)
            return SYSCTL_FIXED | (map << SYSCTL_MAP);
        if (map)
            return (a == SFR_PWR2_ADDR) ? pwr2 : -1;
        case (a)
            SFR_STATUS_ADDR: return program_status_word;
            SFR_USBCTL_ADDR: return usb;
            default:         return -1;
        endcase
    endfunction

    task automatic sfr_wr(logic [7:0] a, logic [7:0] v, logic b = 1'b0, logic [2:0] i = 3'h0);
        int o;
        o = mdl_rd(a);
        @(posedge core_clk);
        sfr_req <= '{a, v, 1'b1, 1'b0, b, i};
        @(posedge core_clk);
        sfr_req.wr <= 1'b0;
        if (b)
            v = (a[2:0] == 3'h0) ? 8'((o & ~(1 << i)) | (v[0] << i)) : 8'(o);
        if (o >= 0 && a == SFR_STATUS_ADDR)
            program_status_word = (v & 8'hFE) | (program_status_word & 1);
        if (o >= 0 && a == SFR_SYSCTL_ADDR)
            map = v[SYSCTL_MAP];
        if (o >= 0 && a == SFR_USBCTL_ADDR)
            usb = v & USBCTL_MASK;
        if (o >= 0 && a == SFR_PWR2_ADDR)
            pwr2 = v & PWR2_MASK;
    endtask

    task automatic sfr_rd(logic [7:0] a, logic b = 1'b0, logic [2:0] i = 3'h0);
        int e;
        e = mdl_rd(a);
        if (b && e >= 0 && a[2:0] == 3'h0)
            e = (e >> i) & 1;
        @(posedge core_clk);
        sfr_req <= '{a, 8'h00, 1'b0, 1'b1, b, i};
        @(posedge core_clk);
        sfr_req.rd <= 1'b0;
        #1;
        chk("sfr_claim", e >= 0, sfr_claim);
        chk("sfr_rdata", e < 0 ? 0 : e, sfr_rdata);
    endtask

    task automatic alu(logic cy, logic ac, logic ov, logic [7:0] acc);
        @(posedge core_clk);
        alu_flags <= '{1'b1, cy, 1'b1, ac, 1'b1, ov};
        acc_value <= acc;
        instr_done <= 1'b1;
        @(posedge core_clk);
        alu_flags <= '0;
        instr_done <= 1'b0;
        program_status_word = (program_status_word & 8'h3A) | (cy << 7) | (ac << 6) | (ov << 2) | (^acc);
    endtask

    // ****
    // scenarios
    // ****
    initial
    begin
        void'($urandom(8));
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        for (int k = 0; k < 5; k++) sfr_rd(ra[k]);
        $display("test reset values done");
        for (int b = 0; b < 4; b++)
        begin
            sfr_wr(SFR_STATUS_ADDR, 8'(($urandom & 8'hE7) | (b << 3)));
            sfr_rd(SFR_STATUS_ADDR);
            for (int i = 0; i < 8; i++)
            begin
                @(posedge core_clk);
                wreg_idx <= 3'(i);
                #1;
                chk("wreg_addr", b * 8 + i, wreg_addr);
            end
        end
        $display("test banks done");
        repeat (6)
        begin
            alu(1'($urandom), 1'($urandom), 1'($urandom), 8'($urandom));
            sfr_rd(SFR_STATUS_ADDR);
        end
        sfr_wr(SFR_STATUS_ADDR, 8'h01, 1'b1, 3'h5);
        sfr_wr(SFR_SYSCTL_ADDR, 8'h01, 1'b1, 3'h4);
        sfr_rd(SFR_STATUS_ADDR);
        sfr_rd(SFR_STATUS_ADDR, 1'b1, 3'h5);
        sfr_rd(SFR_SYSCTL_ADDR);
        $display("test flags done");
        for (int v = 0; v < 8; v++)
        begin
            sfr_wr(SFR_USBCTL_ADDR, 8'((v << 5) | ($urandom & 8'h1F)));
            sfr_rd(SFR_USBCTL_ADDR);
            chk("usb_pll_enable", v & 1, usb_pll_enable);
            chk("usb_fs_select", (v >> 1) & 1, usb_fs_select);
            chk("usb_clk_gate", v >> 2, usb_clk_gate);
        end
        lv = usb_ls_clk;
        @(posedge core_clk);
        #1;
        chk("usb_ls_clk", !lv, usb_ls_clk);
        chk("usb_pll_factor", 4, usb_pll_factor);
        $display("test usb clock done");
        repeat (4)
        begin
            d = 8'($urandom);
            @(posedge core_clk);
            xdata_addr_in <= 16'($urandom);
            iram_req <= '{8'hFF - d, d, 1'b1};
            @(posedge core_clk);
            iram_req.we <= 1'b0;
            #1;
            chk("xdata_addr", xdata_addr_in, xdata_addr);
            @(posedge core_clk);
            #1;
            chk("iram_rdata", d, iram_rdata);
        end
        $display("test memories done");
        sfr_wr(SFR_SYSCTL_ADDR, 8'h10);
        sfr_rd(SFR_STATUS_ADDR);
        d = 8'($urandom);
        sfr_wr(SFR_PWR2_ADDR, d);
        repeat (20) @(posedge core_clk);
        sfr_rd(SFR_PWR2_ADDR);
        chk("pwr2_value", d & PWR2_MASK, pwr2_value);
        sfr_rd(SFR_SYSCTL_ADDR);
        sfr_wr(SFR_SYSCTL_ADDR, 8'h00);
        sfr_rd(SFR_STATUS_ADDR);
        sfr_rd(SFR_PWR2_ADDR);
        $display("test mapped area done");
        @(posedge core_clk);
        reset_pin <= 1'b1;
        repeat (12) @(posedge core_clk);
        reset_pin <= 1'b0;
        repeat (3) @(posedge core_clk);
        program_status_word = 0;
        map = 0;
        pwr2 = 0;
        usb = 0;
        for (int k = 0; k < 5; k++) sfr_rd(ra[k]);
        chk("pwr2_value", 0, pwr2_value);
        $display("test pin reset done");
        wrap_up();
    end
endmodule
